/* File: imu_regs.svh */
// Purpose: constants for the integer multiply unit
// Assumes: included by bare name
// Notes:   condition codes follow the usual 4-bit encoding
`ifndef IMU_REGS_SVH
`define IMU_REGS_SVH
`define IMU_BITS_PER_CYCLE 6'd8
`define IMU_MAX_ARRAY      3'd4
`define IMU_COND_AL        4'h0e
`define IMU_COND_NV        4'h0f
`endif

/* File: imu_pkg.sv */
// Purpose: types for the integer multiply unit
// Assumes: nothing
// Notes:   operation codes are driven by decode
package imu_pkg;
  typedef enum logic [2:0] {
    IMU_OP_MUL   = 3'h0,  // short_multiply
    IMU_OP_MLA   = 3'h1,  // short_multiply_accumulate
    IMU_OP_UNSIGNED_LONG_MULTIPLY = 3'h4,  // unsigned_long_multiply
    IMU_OP_UNSIGNED_LONG_MULTIPLY_ACCUMULATE = 3'h5,  // unsigned_long_multiply_accumulate
    IMU_OP_SIGNED_LONG_MULTIPLY = 3'h6,  // signed_long_multiply
    IMU_OP_SIGNED_LONG_MULTIPLY_ACCUMULATE = 3'h7   // signed_long_multiply_accumulate
  } imu_op_e;
  typedef enum logic [2:0] {
    IMU_IDLE = 3'b001,
    IMU_RUN  = 3'b010,
    IMU_DONE = 3'b100
  } imu_state_e;
endpackage : imu_pkg

/* File: imu_booth_step.sv */
// Purpose: one radix-2 Booth step group retiring 8 multiplier bits
// Assumes: 66-bit signed partial product
// Notes:   pure combinational slice of the array
`timescale 1ns/1ps
module imu_booth_step
(
  // Partial state in
  input  wire logic [65:0] acc_i,
  input  wire logic [65:0] mcand_i,
  input  wire logic [7:0]  mbits_i,
  input  wire logic        prev_i,
  input  wire logic [5:0]  shift_i,
  // Partial state out
  output logic      [65:0] acc_o
);
  // Booth recode each bit: +1, -1 or 0 times shifted multiplicand
  always_comb
  begin
    logic [65:0] a;
    logic        p;
    a = acc_i;
    p = prev_i;
    for (int k = 0; k < 8; k++)
    begin
      if (mbits_i[k] && !p)
        a = a - (mcand_i << (shift_i + 6'(k)));
      else if (!mbits_i[k] && p)
        a = a + (mcand_i << (shift_i + 6'(k)));
      p = mbits_i[k];
    end
    acc_o = a;
  end
endmodule : imu_booth_step

/* File: imu_multiply_unit.sv */
// Purpose: integer multiply unit, short and long forms, Booth array
// Assumes: decode holds operands steady only at start_i
// Notes:   one array cycle per 8 multiplier bits, flags optional
// Contract
// - execute only when condition passes
// - Booth array retires eight bits per cycle
// - short multiply writes product, ignores addend
// - short accumulate adds addend to product
// - short result is low 32 bits
// - any other register sharing works correctly
// - flags change only with set-flags bit
// - N from bit 31, Z on zero
// - carry arbitrary, overflow kept on short
// - short cycles m, accumulate m+1
// - m from sign-extension of multiplier
// - long multiply gives full 64-bit product
// - long accumulate adds high:low pair
// - unsigned or signed treats all operands alike
// - long flags N bit 63, Z 64-bit
// - long cycles m+1, accumulate m+2
// - unsigned shortens only on zero bits
`timescale 1ns/1ps
`include "imu_regs.svh"
module imu_multiply_unit
  import imu_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Operation issue
  input  wire logic        start_i,
  input  wire logic [2:0]  op_i,
  input  wire logic [3:0]  cond_i,
  input  wire logic        set_flags_i,
  input  wire logic [31:0] multiplicand_i,
  input  wire logic [31:0] multiplier_i,
  input  wire logic [31:0] addend_i,
  input  wire logic [31:0] acc_high_i,
  input  wire logic [31:0] acc_low_i,
  // Current status word flags
  input  wire logic        negative_flag_i,
  input  wire logic        zero_flag_i,
  input  wire logic        carry_flag_i,
  input  wire logic        overflow_flag_i,
  // Results
  output logic             busy_o,
  output logic             done_o,
  output logic             write_low_o,
  output logic             write_high_o,
  output logic [31:0]      result_low_o,
  output logic [31:0]      result_high_o,
  // Flag update
  output logic             flags_we_o,
  output logic             negative_flag_o,
  output logic             zero_flag_o,
  output logic             carry_flag_o,
  output logic             overflow_flag_o
);
  // Condition evaluation against the current flags
  function automatic logic cond_pass(input logic [3:0] c,
                                     input logic n, input logic z,
                                     input logic cy, input logic v);
    logic r;
    r = 1'b0;
    unique case (c)
      4'h0: r = z;
      4'h1: r = !z;
      4'h2: r = cy;
      4'h3: r = !cy;
      4'h4: r = n;
      4'h5: r = !n;
      4'h6: r = v;
      4'h7: r = !v;
      4'h8: r = cy && !z;
      4'h9: r = !cy || z;
      4'ha: r = (n == v);
      4'hb: r = (n != v);
      4'hc: r = !z && (n == v);
      4'hd: r = z || (n != v);
      4'he: r = 1'b1;
      4'hf: r = 1'b0;
    endcase
    return r;
  endfunction : cond_pass

  // Array cycle count from the multiplier's upper bits
  function automatic logic [2:0] array_count(input logic [31:0] b,
                                             input logic sgn);
    logic [2:0] m;
    m = `IMU_MAX_ARRAY;
    if (b[31:24] == 8'h00 || (sgn && b[31:24] == 8'hff)) m = 3'd3;
    if (b[31:16] == 16'h0000 || (sgn && b[31:16] == 16'hffff))
      m = 3'd2;
    if (b[31:8] == 24'h00_0000 || (sgn && b[31:8] == 24'hff_ffff))
      m = 3'd1;
    return m;
  endfunction : array_count

  imu_state_e  state_reg, state_next;
  logic [65:0] acc_reg, acc_next;
  logic [65:0] mcand_reg, mcand_next;
  logic [32:0] mplier_reg, mplier_next;
  logic [2:0]  cnt_reg, cnt_next;      // array cycles remaining after this one
  logic [5:0]  shift_reg, shift_next;
  logic        prev_reg, prev_next;
  logic [2:0]  op_reg, op_next;
  logic        sf_reg, sf_next;
  logic [1:0]  extra_n;
  logic [65:0] step_acc;
  logic        is_long, is_acc, is_sgn;

  assign is_long = op_i[2];
  assign is_acc  = op_i[0];
  assign is_sgn  = op_i[1] || !op_i[2];

  // One 8-bit slice of the Booth array per cycle
  imu_booth_step u_step (
    .acc_i   (acc_reg),
    .mcand_i (mcand_reg),
    .mbits_i (mplier_reg[7:0]),
    .prev_i  (prev_reg),
    .shift_i (shift_reg),
    .acc_o   (step_acc)
  );

  // Sequencer next state
  always_comb
  begin
    state_next  = state_reg;
    acc_next    = acc_reg;
    mcand_next  = mcand_reg;
    mplier_next = mplier_reg;
    cnt_next    = cnt_reg;
    shift_next  = shift_reg;
    prev_next   = prev_reg;
    op_next     = op_reg;
    sf_next     = sf_reg;
    extra_n     = 2'd0;
    unique case (state_reg)
      IMU_IDLE:
      begin
        if (start_i && cond_pass(cond_i, negative_flag_i, zero_flag_i,
                                 carry_flag_i, overflow_flag_i))
        begin
          op_next = op_i;
          sf_next = set_flags_i;
          // Signed treat sign-extends, unsigned zero-extends
          mcand_next = is_sgn ? {{34{multiplicand_i[31]}}, multiplicand_i}
                              : {34'h0_0000_0000, multiplicand_i};
          mplier_next = {is_sgn & multiplier_i[31], multiplier_i};
          if (!is_long)
            acc_next = is_acc ? {34'h0_0000_0000, addend_i}
                              : 66'h0_0000_0000_0000_0000;
          else if (is_acc)
            acc_next = is_sgn ? {{2{acc_high_i[31]}}, acc_high_i, acc_low_i}
                              : {2'b00, acc_high_i, acc_low_i};
          else
            acc_next = 66'h0_0000_0000_0000_0000;
          cnt_next = array_count(multiplier_i,
                                 is_sgn);
          // Extra internal cycles: long +1, accumulate +1
          extra_n = {1'b0, is_long} + {1'b0, is_acc};
          cnt_next = cnt_next + 3'(extra_n) - 3'd1;
          shift_next = 6'd0;
          prev_next  = 1'b0;
          state_next = IMU_RUN;
        end
      end
      IMU_RUN:
      begin
        // Array advances until multiplier bits are spent
        if (mplier_reg != {33{prev_reg}} || shift_reg == 6'd0)
        begin
          acc_next    = step_acc;
          prev_next   = mplier_reg[7];
          mplier_next = {{8{mplier_reg[32]}}, mplier_reg[32:8]};
          shift_next  = shift_reg + `IMU_BITS_PER_CYCLE;
          // Fold the boundary digit into this cycle so m steps suffice
          if (mplier_next == {33{mplier_reg[32]}} &&
              mplier_reg[7] != mplier_reg[32])
          begin
            prev_next = mplier_reg[32];
            if (mplier_reg[32])
              acc_next = step_acc - (mcand_reg << shift_next);
            else
              acc_next = step_acc + (mcand_reg << shift_next);
          end
        end
        if (cnt_reg == 3'd0)
          state_next = IMU_DONE;
        else
          cnt_next = cnt_reg - 3'd1;
      end
      IMU_DONE:
        state_next = IMU_IDLE;
      default:
        state_next = IMU_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg  <= IMU_IDLE;
      acc_reg    <= 66'h0_0000_0000_0000_0000;
      mcand_reg  <= 66'h0_0000_0000_0000_0000;
      mplier_reg <= 33'h0_0000_0000;
      cnt_reg    <= 3'd0;
      shift_reg  <= 6'd0;
      prev_reg   <= 1'b0;
      op_reg     <= 3'd0;
      sf_reg     <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      acc_reg    <= acc_next;
      mcand_reg  <= mcand_next;
      mplier_reg <= mplier_next;
      cnt_reg    <= cnt_next;
      shift_reg  <= shift_next;
      prev_reg   <= prev_next;
      op_reg     <= op_next;
      sf_reg     <= sf_next;
    end
  end

  logic [31:0] lo_next, hi_next;
  logic        wl_next, wh_next, fwe_next, n_next, z_next, c_next, v_next;
  logic [31:0] lo_reg, hi_reg;
  logic        wl_reg, wh_reg, fwe_reg, n_reg, z_reg, c_reg, v_reg;

  // Result and flag writeback, one pulse after the last array cycle
  always_comb
  begin
    lo_next  = lo_reg;
    hi_next  = hi_reg;
    wl_next  = 1'b0;
    wh_next  = 1'b0;
    fwe_next = 1'b0;
    n_next   = n_reg;
    z_next   = z_reg;
    c_next   = c_reg;
    v_next   = v_reg;
    if (state_reg == IMU_DONE)
    begin
      lo_next = acc_reg[31:0];
      hi_next = acc_reg[63:32];
      wl_next = 1'b1;
      wh_next = op_reg[2];
      fwe_next = sf_reg;
      c_next  = carry_flag_i;
      v_next  = overflow_flag_i;
      if (op_reg[2])
      begin
        n_next = acc_reg[63];
        z_next = (acc_reg[63:0] == 64'h0000_0000_0000_0000);
      end
      else
      begin
        n_next = acc_reg[31];
        z_next = (acc_reg[31:0] == 32'h0000_0000);
      end
    end
  end

  // Writeback registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      lo_reg  <= 32'h0000_0000;
      hi_reg  <= 32'h0000_0000;
      wl_reg  <= 1'b0;
      wh_reg  <= 1'b0;
      fwe_reg <= 1'b0;
      n_reg   <= 1'b0;
      z_reg   <= 1'b0;
      c_reg   <= 1'b0;
      v_reg   <= 1'b0;
    end
    else
    begin
      lo_reg  <= lo_next;
      hi_reg  <= hi_next;
      wl_reg  <= wl_next;
      wh_reg  <= wh_next;
      fwe_reg <= fwe_next;
      n_reg   <= n_next;
      z_reg   <= z_next;
      c_reg   <= c_next;
      v_reg   <= v_next;
    end
  end

  // Stall held through the done state; it drops in the cycle the writeback pulse goes out
  assign busy_o          = (state_reg != IMU_IDLE);
  assign done_o          = wl_reg;
  assign write_low_o     = wl_reg;
  assign write_high_o    = wh_reg;
  assign result_low_o    = lo_reg;
  assign result_high_o   = hi_reg;
  assign flags_we_o      = fwe_reg;
  assign negative_flag_o = n_reg;
  assign zero_flag_o     = z_reg;
  assign carry_flag_o    = c_reg;
  assign overflow_flag_o = v_reg;
endmodule : imu_multiply_unit

/* File: imu_mul_assertions.sv */
// Purpose: port checks for the multiply unit
// Assumes: bound to imu_multiply_unit
// Notes:   one clock domain only
`timescale 1ns/1ps
`include "imu_regs.svh"
module imu_mul_checker
(
  // Clock, reset and issue
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        start_i,
  input wire logic [3:0]  cond_i,
  input wire logic        overflow_flag_i,
  // Unit outputs
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        write_high_o,
  input wire logic [31:0] result_low_o,
  input wire logic [31:0] result_high_o,
  input wire logic        flags_we_o,
  input wire logic        negative_flag_o,
  input wire logic        zero_flag_o,
  input wire logic        overflow_flag_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Issue and refusal by condition
  issue_busy_a: assert property
    (start_i && !busy_o && cond_i == `IMU_COND_AL |=> busy_o)
    else $error("issue not taken");
  never_run_a: assert property
    (start_i && !busy_o && cond_i == `IMU_COND_NV |=> !busy_o)
    else $error("never condition ran");
  // Length of the array phase
  run_length_a: assert property
    ($rose(busy_o) |-> busy_o[*2] ##[1:6] done_o)
    else $error("bad run length");
  done_idle_a: assert property
    (done_o |-> !busy_o)
    else $error("done while busy");
  high_long_a: assert property
    (write_high_o |-> done_o)
    else $error("high write without done");
  result_hold_a: assert property
    ($changed(result_low_o) |-> done_o)
    else $error("result moved without done");
  // Flag values on update
  short_flags_a: assert property
    (flags_we_o && !write_high_o |-> negative_flag_o == result_low_o[31]
      && zero_flag_o == (result_low_o == 32'h0000_0000))
    else $error("short flags wrong");
  long_flags_a: assert property
    (flags_we_o && write_high_o |-> negative_flag_o == result_high_o[31]
      && zero_flag_o == ({result_high_o, result_low_o} == 64'h0))
    else $error("long flags wrong");
  ovf_kept_a: assert property
    (flags_we_o |-> overflow_flag_o == overflow_flag_i)
    else $error("overflow changed");
  cover property (done_o && write_high_o);
  cover property (flags_we_o && zero_flag_o);
  cover property (start_i && busy_o);
endmodule : imu_mul_checker

/* File: imu_flag_model.sv */
// Purpose: status word flags held by the pipeline
// Assumes: flag update strobe comes from the unit
// Notes:   bench may load flags; an update wins
`timescale 1ns/1ps
module imu_flag_model
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Bench load and unit update, N Z C V
  input  wire logic       load_i,
  input  wire logic [3:0] load_val_i,
  input  wire logic       we_i,
  input  wire logic [3:0] new_i,
  output logic      [3:0] flags_o
);
  // Operands are values, so no register clash can arise
  always_ff @(posedge clk_i)
    if (!rst_n_i) flags_o <= 4'h0;
    else if (we_i) flags_o <= new_i;
    else if (load_i) flags_o <= load_val_i;
endmodule : imu_flag_model

/* File: tb_top.sv */
// Purpose: self-checking bench for the multiply unit
// Assumes: inputs driven on the falling edge
// Notes:   completions matched in issue order
`timescale 1ns/1ps
module tb_top;
  import imu_pkg::*;
  typedef struct {logic [63:0] r; bit l, s; logic n, z, v, cy;
                  int c;} imu_exp_s;
  logic        clk_i = 0, rst_n_i = 0, start_i = 0, set_flags_i = 0;
  logic        load = 0, busy_o, done_o, write_low_o, write_high_o;
  logic        flags_we_o, negative_flag_o, zero_flag_o;
  logic        carry_flag_o, overflow_flag_o;
  logic [2:0]  op_i = 3'h0;
  logic [3:0]  cond_i = 4'h0, lflags = 4'h0, flags;
  logic [31:0] multiplicand_i = 0, multiplier_i = 0, addend_i = 0;
  logic [31:0] acc_high_i = 0, acc_low_i = 0, result_low_o, result_high_o;
  logic [31:0] r, mk;
  int          bad_count = 0, samples_checked = 0, cyc = 0, k;
  imu_exp_s    q[$], me;
  localparam logic [2:0] OPS [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
  imu_multiply_unit DUT (.clk_i, .rst_n_i, .start_i, .op_i, .cond_i,
    .set_flags_i, .multiplicand_i, .multiplier_i, .addend_i, .acc_high_i,
    .acc_low_i, .negative_flag_i(flags[3]), .zero_flag_i(flags[2]),
    .carry_flag_i(flags[1]), .overflow_flag_i(flags[0]), .busy_o, .done_o,
    .write_low_o, .write_high_o, .result_low_o, .result_high_o, .flags_we_o,
    .negative_flag_o, .zero_flag_o, .carry_flag_o, .overflow_flag_o);
  imu_flag_model FM (.clk_i, .rst_n_i, .load_i(load), .load_val_i(lflags),
    .we_i(flags_we_o), .flags_o(flags), .new_i({negative_flag_o,
    zero_flag_o, carry_flag_o, overflow_flag_o}));
  // Clock and cycle count for latency
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  function automatic bit ok(logic [3:0] c, logic [3:0] f);
    bit t;
    case (c[3:1])
      3'h0: t = f[2];
      3'h1: t = f[1];
      3'h2: t = f[3];
      3'h3: t = f[0];
      3'h4: t = f[1] & ~f[2];
      3'h5: t = f[3] == f[0];
      3'h6: t = ~f[2] & (f[3] == f[0]);
      default: t = 1'b1;
    endcase
    return (c == 4'hf) ? 1'b0 : t ^ (c[0] & c != 4'he);
  endfunction : ok
  // Array cycles; unsigned long only shortens on zeros
  function automatic int mcnt(logic [31:0] b, bit u);
    for (int i = 1; i < 4; i++)
      if (b >> 8*i == 0 || !u && b >> 8*i == 32'hffff_ffff >> 8*i)
        return i;
    return 4;
  endfunction : mcnt
  task automatic chk(string nm, logic [63:0] s, logic [63:0] e);
    samples_checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic complete_run();
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  // Issue one operation; twice holds start into the busy cycle
  task automatic issue(logic [2:0] op, logic [3:0] c, bit s, bit twice,
                       logic [31:0] a, b, ad, hi, lo);
    imu_exp_s e;
    logic [63:0] p;
    int n;
    n = 0;
    @(negedge clk_i);
    while (busy_o !== 1'b0 && n < 20)
    begin
      n++;
      @(negedge clk_i);
    end
    if (n == 20) chk("idle", busy_o, 0);
    if (c != 4'he)
    begin
      lflags = 4'($urandom);
      load = 1;
      @(negedge clk_i);
      load = 0;
    end
    {op_i, cond_i, set_flags_i, start_i} = {op, c, s, 1'b1};
    {multiplicand_i, multiplier_i, addend_i} = {a, b, ad};
    {acc_high_i, acc_low_i} = {hi, lo};
    p = op[1] ? {{32{a[31]}}, a} * {{32{b[31]}}, b} : {32'h0, a} * b;
    if (op[0]) p += op[2] ? {hi, lo} : {32'h0, ad};
    e.r = op[2] ? p : {32'h0, p[31:0]};
    {e.l, e.s, e.v, e.cy} = {op[2], s, flags[0], flags[1]};
    e.n = op[2] ? p[63] : p[31];
    e.z = op[2] ? p == 0 : p[31:0] == 0;
    e.c = cyc + 2 + mcnt(b, op[2] & ~op[1]) + (op[2] ? 1 + op[0] : op[0]);
    if (ok(c, flags)) q.push_back(e);
    @(negedge clk_i);
    start_i = twice;
    if (twice)
    begin
      @(negedge clk_i);
      start_i = 0;
    end
  endtask : issue
  // Match each completion against the oldest note
  always @(negedge clk_i)
    if (done_o === 1'b1)
    begin
      me = q.size() ? q.pop_front() : imu_exp_s'{c: -1, default: 0};
      chk("cycles", cyc, me.c);
      chk("res", {me.l ? result_high_o : 32'h0, result_low_o}, me.r);
      chk("wr", {write_high_o, write_low_o, flags_we_o}, {me.l, 1'b1, me.s});
      if (me.s) chk("nzcv", {negative_flag_o, zero_flag_o, carry_flag_o,
        overflow_flag_o}, {me.n, me.z, me.cy, me.v});
    end
  // Directed corners, then a random mix
  initial
  begin
    void'($urandom(61752));
    repeat (12) @(negedge clk_i);
    rst_n_i = 1;
    issue(3'h0, 4'he, 1, 0, 32'hffff_fff6, 32'h0000_0014, 0, 0, 0);
    issue(3'h1, 4'he, 1, 0, 32'h3, 32'h8000_0001, 32'h8000_0001, 0, 0);
    issue(3'h0, 4'he, 1, 1, 32'h1234_5678, 0, 32'hffff_ffff, 0, 0);
    issue(3'h7, 4'he, 1, 0, 1, 32'hffff_ffff, 0, 0, 1);
    issue(3'h5, 4'he, 0, 0, 32'hffff_ffff, 32'hffff_ffff, 0, 1, 2);
    repeat (150)
    begin
      r = $urandom;
      k = $urandom % 4;
      mk = 32'hffff_ffff >> 8 * (3 - k);
      issue(OPS[$urandom % 6], 4'($urandom), 1'($urandom), 0, $urandom,
            $urandom % 2 ? r | ~mk : r & mk, $urandom, $urandom, $urandom);
    end
    repeat (12) @(negedge clk_i);
    chk("pending", q.size(), 0);
    complete_run();
  end
  // Watchdog well past the expected run
  initial
  begin
    #(25 * 4000);
    bad_count++;
    complete_run();
  end
endmodule : tb_top
bind imu_multiply_unit imu_mul_checker CHK (.clk_i, .rst_n_i, .start_i,
  .cond_i, .overflow_flag_i, .busy_o, .done_o, .write_high_o, .result_low_o,
  .result_high_o, .flags_we_o, .negative_flag_o, .zero_flag_o,
  .overflow_flag_o);
